// File: rtl/imupc_pkg.sv
`default_nettype none
package imupc_pkg;
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_PWRCFG = 8'h04;
  localparam logic [7:0] A_SENS = 8'h08;
  localparam logic [7:0] A_ACCCFG = 8'h0C;
  localparam logic [7:0] A_RATECFG = 8'h10;
  localparam logic [7:0] A_LDCTRL = 8'h14;
  localparam logic [7:0] A_LDADDR = 8'h18;
  localparam logic [7:0] A_LDDATA = 8'h1C;
  localparam logic [7:0] A_ACC0 = 8'h20;
  localparam logic [7:0] A_SOFTRST = 8'h38;
  localparam int PC_DPS = 0;
  localparam int SE_AUX = 0;
  localparam int SE_GYR = 1;
  localparam int SE_ACC = 2;
  localparam int SE_TMP = 3;
  localparam int CF_NOISE = 6;
  localparam int CF_FILT = 7;
  localparam int ST_PS = 4;
  localparam int ST_LDDONE = 7;
  localparam int ST_POR = 8;
  localparam int ST_FREE = 9;
  localparam logic [7:0] PWRCFG_RST = 8'h01;
  localparam logic [7:0] SENS_RST = 8'h00;
  localparam logic [7:0] ACCCFG_RST = 8'h00;
  localparam logic [7:0] RATECFG_RST = 8'h00;
  localparam logic [7:0] SOFTRST_KEY = 8'h5A;
  localparam logic [3:0] MSG_IDLE = 4'h0;
  localparam logic [3:0] MSG_OK = 4'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int IMG_AW = 13;
  localparam int IMG_BYTES = 8192;
  localparam int CNT_W = 20;
  localparam int CLK_KHZ = 40000;
  localparam int STARTUP_US = 450;
  localparam int STARTUP_CYC = (STARTUP_US * CLK_KHZ + 999) / 1000;
  localparam int LOAD_MAX_MS = 20;
  localparam int LOAD_MAX_CYC = LOAD_MAX_MS * CLK_KHZ;
  localparam int LOAD_LAT_CYC = 100;
  typedef enum logic [2:0] {
    PS_SUSPEND, PS_CONFIG, PS_LOWPWR, PS_NORMAL, PS_PERF
  } imupc_pstate_type;
endpackage : imupc_pkg
`default_nettype wire

// File: rtl/imupc_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface imupc_seq_if;
  logic restart;
  logic load_go;
  logic dps;
  logic por_ready;
  logic free_ready;
  logic init_done;
  logic [3:0] msg;
  modport ctl (output restart, load_go, dps, input por_ready, free_ready, init_done, msg);
  modport seq (input restart, load_go, dps, output por_ready, free_ready, init_done, msg);
endinterface : imupc_seq_if
`default_nettype wire

// File: rtl/imupc_seq.sv
`timescale 1ns/1ps
`default_nettype none
module imupc_seq #(
  parameter int STARTUP_CYC = imupc_pkg::STARTUP_CYC,
  parameter int LOAD_LAT_CYC = imupc_pkg::LOAD_LAT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  imupc_seq_if.seq sq
);
  typedef struct packed {
    logic [imupc_pkg::CNT_W-1:0] por_cnt;
    logic por_rdy;
    logic [imupc_pkg::CNT_W-1:0] free_cnt;
    logic free_rdy;
    logic [imupc_pkg::CNT_W-1:0] lat_cnt;
    logic busy;
    logic [3:0] msg;
  } imupc_seq_type;

  localparam logic [imupc_pkg::CNT_W-1:0] POR_END = imupc_pkg::CNT_W'(STARTUP_CYC - 1);
  localparam logic [imupc_pkg::CNT_W-1:0] LAT_END = imupc_pkg::CNT_W'(LOAD_LAT_CYC - 1);

  imupc_seq_type s_r, s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (sq.restart) begin
      // Soft reset restarts the start-up wait as power-on does
      s_nxt = '0;
    end else begin
      if (!s_r.por_rdy) begin
        if (s_r.por_cnt == POR_END) s_nxt.por_rdy = 1'b1;
        else s_nxt.por_cnt = s_r.por_cnt + 1'b1;
      end
      if (sq.dps) begin
        s_nxt.free_rdy = 1'b0;
        s_nxt.free_cnt = '0;
      end else if (!s_r.free_rdy) begin
        if (s_r.free_cnt == POR_END) s_nxt.free_rdy = 1'b1;
        else s_nxt.free_cnt = s_r.free_cnt + 1'b1;
      end
      if (sq.load_go && !s_r.busy) begin
        s_nxt.busy = 1'b1;
        s_nxt.lat_cnt = '0;
        s_nxt.msg = imupc_pkg::MSG_IDLE;
      end else if (s_r.busy) begin
        if (s_r.lat_cnt == LAT_END) begin
          s_nxt.busy = 1'b0;
          s_nxt.msg = imupc_pkg::MSG_OK;
        end else begin
          s_nxt.lat_cnt = s_r.lat_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign sq.por_ready = s_r.por_rdy;
  assign sq.free_ready = s_r.free_rdy;
  assign sq.msg = s_r.msg;
  assign sq.init_done = (s_r.msg == imupc_pkg::MSG_OK);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_por_time;
    $rose(s_r.por_rdy) |-> $past(s_r.por_cnt) == POR_END && !$past(sq.restart);
  endproperty
  a_por_time: assert property (p_por_time) else $error("startup ready off count");

  property p_msg_time;
    $rose(sq.init_done) |-> $past(s_r.busy) && $past(s_r.lat_cnt) == LAT_END;
  endproperty
  a_msg_time: assert property (p_msg_time) else $error("load status early");

  property p_free_dps;
    sq.dps && !sq.restart |=> !s_r.free_rdy && s_r.free_cnt == '0;
  endproperty
  a_free_dps: assert property (p_free_dps) else $error("free ready under save");
endmodule : imupc_seq
`default_nettype wire

// File: rtl/imupc_top.sv
`timescale 1ns/1ps
`default_nettype none
module imupc_top #(
  parameter int STARTUP_CYC = imupc_pkg::STARTUP_CYC,
  parameter int LOAD_LAT_CYC = imupc_pkg::LOAD_LAT_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic ACC_STROBE,
  input wire logic [15:0] ACC_X,
  input wire logic [15:0] ACC_Y,
  input wire logic [15:0] ACC_Z,
  output logic [2:0] POWER_STATE,
  output logic SAMPLE_LOG_EN,
  output logic INIT_DONE
);
  typedef struct packed {
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [7:0] w_d;
    logic w_s;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] pcfg;
    logic [7:0] sens;
    logic [7:0] acfg;
    logic [7:0] rcfg;
    logic ld_done;
    logic [imupc_pkg::IMG_AW-1:0] ld_idx;
    logic [47:0] live;
    logic [2:0] lock;
    logic [23:0] hold;
    imupc_pkg::imupc_pstate_type ps;
    logic log_en;
  } imupc_state_type;

  localparam imupc_state_type RST = '{
    pcfg: imupc_pkg::PWRCFG_RST,
    sens: imupc_pkg::SENS_RST,
    acfg: imupc_pkg::ACCCFG_RST,
    rcfg: imupc_pkg::RATECFG_RST,
    ps: imupc_pkg::PS_SUSPEND,
    default: '0
  };

  imupc_state_type s_r, s_nxt;
  logic [7:0] img_mem [imupc_pkg::IMG_BYTES];
  logic mem_we;
  logic [imupc_pkg::IMG_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [1:0] rd_ax;
  logic [7:0] ar_off;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;

  imupc_seq_if sq();

  imupc_seq #(
    .STARTUP_CYC(STARTUP_CYC),
    .LOAD_LAT_CYC(LOAD_LAT_CYC)
  ) imupc_seq_inst (
    .clk(CLK),
    .resetn(RESETN),
    .sq(sq.seq)
  );

  // Locked before start-up completes; decode error outside the map
  function automatic logic [1:0] resp_of(input logic [7:0] a, input logic rdy);
    if (!rdy) return imupc_pkg::RESP_SLVERR;
    if (a[1:0] != 2'h0 || a > imupc_pkg::A_SOFTRST) return imupc_pkg::RESP_DECERR;
    return imupc_pkg::RESP_OKAY;
  endfunction : resp_of

  function automatic imupc_pkg::imupc_pstate_type pstate(
    input logic done, input logic [7:0] pc, input logic [7:0] se,
    input logic [7:0] ac, input logic [7:0] rc);
    logic acc;
    logic gyr;
    acc = se[imupc_pkg::SE_ACC];
    gyr = se[imupc_pkg::SE_GYR];
    if (!done) return imupc_pkg::PS_SUSPEND;
    if (!acc && !gyr) begin
      if (pc[imupc_pkg::PC_DPS]) return imupc_pkg::PS_SUSPEND;
      return imupc_pkg::PS_CONFIG;
    end
    if (gyr && rc[imupc_pkg::CF_FILT] && rc[imupc_pkg::CF_NOISE]) begin
      return imupc_pkg::PS_PERF;
    end
    if ((!acc || ac[imupc_pkg::CF_FILT]) && (!gyr || rc[imupc_pkg::CF_FILT])) begin
      return imupc_pkg::PS_NORMAL;
    end
    // Short of the performance case, any selected sensor without its filter bit falls to the duty-cycled state
    return imupc_pkg::PS_LOWPWR;
  endfunction : pstate

  assign ar_off = S_AXI_ARADDR - imupc_pkg::A_ACC0;
  assign rd_ax = ar_off[4:3];
  assign rd_resp = resp_of(S_AXI_ARADDR, sq.por_ready);
  assign wr_resp = resp_of(s_r.aw_a, sq.por_ready);

  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_wa = s_r.ld_idx;
    mem_wd = s_r.w_d;
    sq.load_go = 1'b0;
    sq.restart = 1'b0;
    if (ACC_STROBE) s_nxt.live = {ACC_Z, ACC_Y, ACC_X};
    if (S_AXI_AWVALID && !s_r.aw_v) begin
      s_nxt.aw_v = 1'b1;
      s_nxt.aw_a = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s_r.w_v) begin
      s_nxt.w_v = 1'b1;
      s_nxt.w_d = S_AXI_WDATA[7:0];
      s_nxt.w_s = S_AXI_WSTRB[0];
    end
    if (s_r.bvalid && S_AXI_BREADY) s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && S_AXI_RREADY) s_nxt.rvalid = 1'b0;

    if (S_AXI_ARVALID && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = rd_resp;
      s_nxt.rdata = '0;
      if (rd_resp == imupc_pkg::RESP_OKAY) begin
        if (S_AXI_ARADDR >= imupc_pkg::A_ACC0 && S_AXI_ARADDR < imupc_pkg::A_SOFTRST) begin
          if (!ar_off[2]) begin
            s_nxt.rdata[7:0] = s_r.live[rd_ax*16 +: 8];
            s_nxt.lock[rd_ax] = 1'b1;
            s_nxt.hold[rd_ax*8 +: 8] = s_r.live[rd_ax*16+8 +: 8];
          end else begin
            s_nxt.rdata[7:0] = s_r.lock[rd_ax] ? s_r.hold[rd_ax*8 +: 8]
                                               : s_r.live[rd_ax*16+8 +: 8];
            s_nxt.lock[rd_ax] = 1'b0;
          end
        end else begin
          unique case (S_AXI_ARADDR)
            imupc_pkg::A_STATUS: begin
              s_nxt.rdata[3:0] = sq.msg;
              s_nxt.rdata[imupc_pkg::ST_PS +: 3] = s_r.ps;
              s_nxt.rdata[imupc_pkg::ST_LDDONE] = s_r.ld_done;
              s_nxt.rdata[imupc_pkg::ST_POR] = sq.por_ready;
              s_nxt.rdata[imupc_pkg::ST_FREE] = sq.free_ready;
            end
            imupc_pkg::A_PWRCFG: s_nxt.rdata[7:0] = s_r.pcfg;
            imupc_pkg::A_SENS: s_nxt.rdata[7:0] = s_r.sens;
            imupc_pkg::A_ACCCFG: s_nxt.rdata[7:0] = s_r.acfg;
            imupc_pkg::A_RATECFG: s_nxt.rdata[7:0] = s_r.rcfg;
            imupc_pkg::A_LDCTRL: s_nxt.rdata[0] = s_r.ld_done;
            imupc_pkg::A_LDADDR: s_nxt.rdata[11:0] = s_r.ld_idx[imupc_pkg::IMG_AW-1:1];
            imupc_pkg::A_LDDATA: begin
              s_nxt.rdata[7:0] = img_mem[s_r.ld_idx];
              s_nxt.ld_idx = s_r.ld_idx + 1'b1;
            end
            default: s_nxt.rdata = '0;
          endcase
        end
      end
    end

    if (s_r.aw_v && s_r.w_v && !s_r.bvalid) begin
      s_nxt.aw_v = 1'b0;
      s_nxt.w_v = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_resp;
      // Only the low byte lane carries register data
      if (wr_resp == imupc_pkg::RESP_OKAY && s_r.w_s) begin
        unique case (s_r.aw_a)
          imupc_pkg::A_PWRCFG: s_nxt.pcfg = {7'h00, s_r.w_d[imupc_pkg::PC_DPS]};
          imupc_pkg::A_SENS: s_nxt.sens = {4'h0, s_r.w_d[3:0]};
          imupc_pkg::A_ACCCFG: s_nxt.acfg = s_r.w_d;
          imupc_pkg::A_RATECFG: s_nxt.rcfg = s_r.w_d;
          imupc_pkg::A_LDCTRL: begin
            // A second completion would restart the engine, so it is dropped
            if (s_r.w_d[0] && !s_r.ld_done) begin
              s_nxt.ld_done = 1'b1;
              sq.load_go = 1'b1;
            end
          end
          imupc_pkg::A_LDADDR: begin
            s_nxt.ld_idx = {4'h0, s_r.w_d, 1'b0};
          end
          imupc_pkg::A_LDDATA: begin
            mem_we = 1'b1;
            s_nxt.ld_idx = s_r.ld_idx + 1'b1;
          end
          imupc_pkg::A_SOFTRST: begin
            if (s_r.w_d == imupc_pkg::SOFTRST_KEY) begin
              sq.restart = 1'b1;
              s_nxt.pcfg = imupc_pkg::PWRCFG_RST;
              s_nxt.sens = imupc_pkg::SENS_RST;
              s_nxt.acfg = imupc_pkg::ACCCFG_RST;
              s_nxt.rcfg = imupc_pkg::RATECFG_RST;
              s_nxt.ld_done = 1'b0;
              s_nxt.ld_idx = '0;
              s_nxt.lock = '0;
            end
          end
          default: s_nxt.bresp = imupc_pkg::RESP_OKAY;
        endcase
      end
    end
    // Register contents survive every state change; only reset or a soft reset clears them
    // Soft reset drops to suspend at once; the status message clears on the same clock edge
    if (sq.restart) s_nxt.ps = imupc_pkg::PS_SUSPEND;
    else s_nxt.ps = pstate(sq.init_done, s_r.pcfg, s_r.sens, s_r.acfg, s_r.rcfg);
    s_nxt.log_en = s_r.sens[imupc_pkg::SE_ACC] | s_r.sens[imupc_pkg::SE_GYR];
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) s_r <= RST;
    else s_r <= s_nxt;
  end

  // No reset on the image store: it is plain memory
  always_ff @(posedge CLK) begin
    if (mem_we) img_mem[mem_wa] <= mem_wd;
  end

  assign sq.dps = s_r.pcfg[imupc_pkg::PC_DPS];
  assign S_AXI_AWREADY = !s_r.aw_v;
  assign S_AXI_WREADY = !s_r.w_v;
  assign S_AXI_BVALID = s_r.bvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_ARREADY = !s_r.rvalid;
  assign S_AXI_RVALID = s_r.rvalid;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = s_r.rresp;
  assign POWER_STATE = s_r.ps;
  assign SAMPLE_LOG_EN = s_r.log_en;
  assign INIT_DONE = sq.init_done;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  property p_suspend;
    !$past(sq.init_done) |-> s_r.ps == imupc_pkg::PS_SUSPEND;
  endproperty
  a_suspend: assert property (p_suspend) else $error("left suspend before init");

  property p_config;
    sq.init_done && !sq.restart && s_r.sens[2:1] == 2'h0 && !s_r.pcfg[0]
      |=> s_r.ps == imupc_pkg::PS_CONFIG;
  endproperty
  a_config: assert property (p_config) else $error("not in config state");

  property p_perf;
    sq.init_done && !sq.restart && s_r.sens[1] && s_r.rcfg[7] && s_r.rcfg[6]
      |=> s_r.ps == imupc_pkg::PS_PERF;
  endproperty
  a_perf: assert property (p_perf) else $error("not in performance state");

  property p_locked;
    !sq.por_ready && s_r.aw_v && s_r.w_v && !s_r.bvalid
      |=> s_r.bvalid && s_r.bresp == imupc_pkg::RESP_SLVERR && $stable(s_r.pcfg);
  endproperty
  a_locked: assert property (p_locked) else $error("write taken before startup");

  property p_shadow;
    sq.por_ready && S_AXI_ARVALID && !s_r.rvalid && S_AXI_ARADDR == imupc_pkg::A_ACC0
      |=> s_r.lock[0] && s_r.hold[7:0] == $past(s_r.live[15:8]);
  endproperty
  a_shadow: assert property (p_shadow) else $error("high byte not frozen");

  property p_once;
    sq.load_go |-> !s_r.ld_done ##1 s_r.ld_done;
  endproperty
  a_once: assert property (p_once) else $error("load completed twice");

  property p_soft;
    sq.restart |=> s_r.sens == 8'h00 && s_r.pcfg[0] && s_r.ps == imupc_pkg::PS_SUSPEND;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset values wrong");

  property p_bpair;
    $rose(s_r.bvalid) |-> $past(s_r.aw_v) && $past(s_r.w_v);
  endproperty
  a_bpair: assert property (p_bpair) else $error("response without both halves");

  property p_data_step;
    s_r.aw_v && s_r.w_v && !s_r.bvalid && wr_resp == imupc_pkg::RESP_OKAY && s_r.w_s
      && s_r.aw_a == imupc_pkg::A_LDDATA |=> s_r.ld_idx == $past(s_r.ld_idx) + 1'b1;
  endproperty
  a_data_step: assert property (p_data_step) else $error("data port did not advance");

  property p_ptr_units;
    s_r.aw_v && s_r.w_v && !s_r.bvalid && wr_resp == imupc_pkg::RESP_OKAY && s_r.w_s
      && s_r.aw_a == imupc_pkg::A_LDADDR |=> s_r.ld_idx == {4'h0, $past(s_r.w_d), 1'b0};
  endproperty
  a_ptr_units: assert property (p_ptr_units) else $error("pointer not in halfwords");

  property p_lowpwr;
    sq.init_done && !sq.restart && s_r.sens[imupc_pkg::SE_ACC]
      && !s_r.sens[imupc_pkg::SE_GYR] && !s_r.acfg[imupc_pkg::CF_FILT]
      |=> s_r.ps == imupc_pkg::PS_LOWPWR;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("not in low-power state");

  property p_normal;
    sq.init_done && !sq.restart && s_r.sens[imupc_pkg::SE_GYR]
      && s_r.rcfg[imupc_pkg::CF_FILT] && !s_r.rcfg[imupc_pkg::CF_NOISE]
      && (!s_r.sens[imupc_pkg::SE_ACC] || s_r.acfg[imupc_pkg::CF_FILT])
      |=> s_r.ps == imupc_pkg::PS_NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("not in normal state");

  property p_log_en;
    s_r.sens[imupc_pkg::SE_ACC] || s_r.sens[imupc_pkg::SE_GYR] |=> s_r.log_en;
  endproperty
  a_log_en: assert property (p_log_en) else $error("sample logging off");
endmodule : imupc_top
`default_nettype wire

// File: verification/imupc_host.sv
`timescale 1ns/1ps
`default_nettype none
module imupc_host (
  input wire logic clk,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  output logic hung
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hung} = 6'h00;
    {awaddr, araddr, wstrb} = 20'h00000;
    wdata = 32'h00000000;
  end
  // Address and data go out together; each drops only once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h000000, v};
    wstrb <= 4'hF;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 2000);
    r = bresp;
    bready <= 1'b0;
    if (!bvalid) hung <= 1'b1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 2000);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (!rvalid) hung <= 1'b1;
  endtask : rd
endmodule : imupc_host
`default_nettype wire

// File: verification/tb_imu_init_power_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("mismatch at %0t: got %h want %h", $time, a, e); \
  end \
end
module tb_imu_init_power_mode_ctrl;
  localparam int SU = 20;
  localparam int LL = 30;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic stb = 1'b0;
  logic [15:0] ax [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, hung;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] pst;
  logic slog, idone;
  int errors = 0;
  int checked = 0;
  imupc_host imupc_host_inst (.clk(CLK), .awvalid, .awready, .awaddr, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .hung);
  imupc_top #(.STARTUP_CYC(SU), .LOAD_LAT_CYC(LL)) imupc_top_inst (.CLK(CLK), .RESETN(RESETN),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_AWADDR(awaddr),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .ACC_STROBE(stb), .ACC_X(ax[0]), .ACC_Y(ax[1]), .ACC_Z(ax[2]),
    .POWER_STATE(pst), .SAMPLE_LOG_EN(slog), .INIT_DONE(idone));
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  always @(posedge hung) begin
    errors++;
    wrap_up();
  end
  task automatic wrap_up;
    if (errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask : cyc
  function automatic logic [7:0] img(input int i);
    return 8'(i * 37 + 5);
  endfunction : img
  task automatic wchk(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
    imupc_host_inst.wr(a, v, r);
    `CHK(r, e)
  endtask : wchk
  // Upper bits beyond the mask are left unjudged
  task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    imupc_host_inst.rd(a, d, r);
    `CHK({r, d[15:0] & m}, {2'h0, e})
  endtask : rchk
  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge CLK);
    stb <= 1'b1;
    ax <= '{x, y, z};
    @(posedge CLK);
    stb <= 1'b0;
  endtask : smp
  task automatic t_boot;
    imupc_host_inst.rd(8'h00, d, r);
    `CHK(r, imupc_pkg::RESP_SLVERR)
    wchk(8'h04, 8'h00, imupc_pkg::RESP_SLVERR);
    cyc(SU);
    rchk(8'h00, 16'h01FF, 16'h0100);
    rchk(8'h04, 16'h00FF, 16'h0001);
    rchk(8'h08, 16'h000F, 16'h0000);
    `CHK({pst, idone}, 4'h0)
    wchk(8'h3C, 8'h00, imupc_pkg::RESP_DECERR);
  endtask : t_boot
  task automatic t_init;
    int n = 0;
    wchk(8'h04, 8'h00, 2'h0);
    cyc(SU);
    rchk(8'h00, 16'h0200, 16'h0200);
    wchk(8'h14, 8'h00, 2'h0);
    wchk(8'h18, 8'h00, 2'h0);
    for (int i = 0; i < 32; i++) begin
      if (i == 16) wchk(8'h18, 8'h08, 2'h0);
      wchk(8'h1C, img(i), 2'h0);
    end
    wchk(8'h18, 8'h00, 2'h0);
    for (int i = 0; i < 32; i++) rchk(8'h1C, 16'h00FF, {8'h00, img(i)});
    wchk(8'h18, 8'h0C, 2'h0);
    rchk(8'h1C, 16'h00FF, {8'h00, img(24)});
    `CHK(idone, 1'b0)
    wchk(8'h14, 8'h01, 2'h0);
    while (idone !== 1'b1 && n < LL + 8) begin
      @(posedge CLK);
      n++;
    end
    `CHK(n >= LL - 6 && n < LL + 8, 1'b1)
    if (idone !== 1'b1) wrap_up();
    rchk(8'h00, 16'h00FF, 16'h0091);
    `CHK(pst, imupc_pkg::PS_CONFIG)
    wchk(8'h14, 8'h01, 2'h0);
    rchk(8'h00, 16'h00FF, 16'h0091);
  endtask : t_init
  task automatic t_modes;
    logic [31:0] cfg [8] = '{32'h01000000, 32'h00000000, 32'h01040000, 32'h01020000,
      32'h00068080, 32'h01020080, 32'h000200C0, 32'h010680C0};
    logic [2:0] ps [8] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        wchk(8'h04 + 8'(4 * k), cfg[i][31 - 8 * k -: 8], 2'h0);
        cyc(SU);
      end
      `CHK(pst, ps[i])
      `CHK(slog, |cfg[i][18:17])
      rchk(8'h00, 16'h0070, {9'h000, ps[i], 4'h0});
      rchk(8'h08, 16'h00FF, {8'h00, cfg[i][23:16]});
      rchk(8'h10, 16'h00FF, {8'h00, cfg[i][7:0]});
    end
  endtask : t_modes
  task automatic t_accel;
    smp(16'h8123, 16'h0456, 16'hF789);
    rchk(8'h20, 16'h00FF, 16'h0023);
    rchk(8'h30, 16'h00FF, 16'h0089);
    smp(16'h7F45, 16'h1111, 16'h2222);
    rchk(8'h24, 16'h00FF, 16'h0081);
    rchk(8'h34, 16'h00FF, 16'h00F7);
    rchk(8'h28, 16'h00FF, 16'h0011);
    rchk(8'h2C, 16'h00FF, 16'h0011);
    wchk(8'h20, 8'h00, 2'h0);
    rchk(8'h20, 16'h00FF, 16'h0045);
    rchk(8'h24, 16'h00FF, 16'h007F);
  endtask : t_accel
  task automatic t_srst;
    wchk(8'h38, imupc_pkg::SOFTRST_KEY, imupc_pkg::RESP_OKAY);
    imupc_host_inst.rd(8'h00, d, r);
    `CHK(r, imupc_pkg::RESP_SLVERR)
    cyc(SU);
    rchk(8'h00, 16'h00FF, 16'h0000);
    rchk(8'h04, 16'h00FF, 16'h0001);
    rchk(8'h08, 16'h00FF, 16'h0000);
    `CHK({pst, idone}, 4'h0)
  endtask : t_srst
  initial begin
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    t_boot();
    t_init();
    t_modes();
    t_accel();
    t_srst();
    wrap_up();
  end
endmodule : tb_imu_init_power_mode_ctrl
`default_nettype wire
